// file: verilog/meir_pkg.sv
// Register map, field positions and reset values of the motion event interrupt router
package meir_pkg;

  // ==========================================================================
  // Register file geometry
  localparam int MEIR_REG_COUNT = 5;
  localparam int MEIR_ADDR_W    = 7;
  localparam int MEIR_DATA_W    = 8;
  localparam int MEIR_MOTION_W  = 6;
  localparam int MEIR_SYSTEM_W  = 6;

  // ==========================================================================
  // Register offsets on the serial register port
  localparam logic [6:0] MEIR_OFS_PIN_A   = 7'h4d;
  localparam logic [6:0] MEIR_OFS_PIN_B   = 7'h4e;
  localparam logic [6:0] MEIR_OFS_SYS_IB  = 7'h4f;
  localparam logic [6:0] MEIR_OFS_ERR_IB  = 7'h50;
  localparam logic [6:0] MEIR_OFS_GEST_IB = 7'h51;

  // ==========================================================================
  // Register indices into the route array
  localparam int MEIR_IDX_PIN_A   = 0;
  localparam int MEIR_IDX_PIN_B   = 1;
  localparam int MEIR_IDX_SYS_IB  = 2;
  localparam int MEIR_IDX_ERR_IB  = 3;
  localparam int MEIR_IDX_GEST_IB = 4;

  // ==========================================================================
  // Reset value, writable bits and unmapped read answer
  localparam logic [7:0] MEIR_ROUTE_RESET = 8'h00;
  localparam logic [7:0] MEIR_MASK_MOTION = 8'h3f;
  localparam logic [7:0] MEIR_MASK_SYSTEM = 8'h3f;
  localparam logic [7:0] MEIR_MASK_ERROR  = 8'h9e;
  localparam logic [7:0] MEIR_READ_IDLE   = 8'h00;

  // ==========================================================================
  // Motion routing fields (pin A, pin B and gesture in-band registers)
  localparam int MEIR_BIT_STEP  = 5;
  localparam int MEIR_BIT_OVF   = 4;
  localparam int MEIR_BIT_TILT  = 3;
  localparam int MEIR_BIT_WAKE  = 2;
  localparam int MEIR_BIT_SLEEP = 1;
  localparam int MEIR_BIT_TAP   = 0;

  // System in-band routing fields
  localparam int MEIR_BIT_FRAME_SYNC     = 5;
  localparam int MEIR_BIT_PLL       = 4;
  localparam int MEIR_BIT_DRDY      = 3;
  localparam int MEIR_BIT_FIFO_LVL  = 2;
  localparam int MEIR_BIT_FIFO_FULL = 1;
  localparam int MEIR_BIT_GAIN      = 0;

  // Error and motion-wake in-band routing fields
  localparam int MEIR_BIT_BUS_ERR = 7;
  localparam int MEIR_BIT_SIG_MOT = 4;
  localparam int MEIR_BIT_WAKE_Z  = 3;
  localparam int MEIR_BIT_WAKE_Y  = 2;
  localparam int MEIR_BIT_WAKE_X  = 1;

  // ==========================================================================
  // Per-register tables, indexed by the indices above
  localparam logic [6:0] MEIR_OFFSETS [MEIR_REG_COUNT] = '{
    MEIR_OFS_PIN_A, MEIR_OFS_PIN_B, MEIR_OFS_SYS_IB, MEIR_OFS_ERR_IB, MEIR_OFS_GEST_IB
  };
  localparam logic [7:0] MEIR_WRITE_MASKS [MEIR_REG_COUNT] = '{
    MEIR_MASK_MOTION, MEIR_MASK_MOTION, MEIR_MASK_SYSTEM, MEIR_MASK_ERROR, MEIR_MASK_MOTION
  };

endpackage : meir_pkg

// file: verilog/meir_route_reg.sv
// One byte-wide routing register with reserved bits held at zero
`timescale 1ns/1ps
module meir_route_reg
#(
  parameter logic [7:0] WRITE_MASK  = 8'hff,
  parameter logic [7:0] RESET_VALUE = 8'h00
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output logic      [7:0] value
);
  import meir_pkg::*;

  // ==========================================================================
  // Per-bit storage; reserved positions never hold state, so they read as zero
  genvar b;
  generate
    for (b = 0; b < MEIR_DATA_W; b++)
    begin : g_bit
      if (WRITE_MASK[b])
      begin : g_live
        logic bitQ;

        // One flop per live bit; the port bit stays a plain wire, so no bit mixes drivers
        always_ff @(posedge clk_sys or posedge rst)
        begin
          if (rst)
            bitQ <= RESET_VALUE[b];
          else if (wrEn)
            bitQ <= wrData[b];
        end

        assign value[b] = bitQ;
      end
      else
      begin : g_rsvd
        assign value[b] = 1'b0;
      end
    end
  endgenerate

endmodule : meir_route_reg

// file: verilog/meir_router.sv
// Motion event interrupt router: routing registers, pin and in-band request gating
`timescale 1ns/1ps

module meir_router
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  input  wire logic                            regWrEn,
  input  wire logic                            regRdEn,
  input  wire logic [meir_pkg::MEIR_ADDR_W-1:0] regAddr,
  input  wire logic [meir_pkg::MEIR_DATA_W-1:0] regWrData,
  output logic      [meir_pkg::MEIR_DATA_W-1:0] regRdData,
  output logic                                 regRdValid,
  input  wire logic                            stepEvent,
  input  wire logic                            stepOverflowEvent,
  input  wire logic                            tiltEvent,
  input  wire logic                            wakeEvent,
  input  wire logic                            sleepEvent,
  input  wire logic                            tapEvent,
  input  wire logic                            frameSyncEvent,
  input  wire logic                            pllLockEvent,
  input  wire logic                            sampleReadyEvent,
  input  wire logic                            fifoLevelEvent,
  input  wire logic                            fifoFullEvent,
  input  wire logic                            gainReadyEvent,
  input  wire logic                            busErrorEvent,
  input  wire logic                            significantMotionEvent,
  input  wire logic                            motionWakeZEvent,
  input  wire logic                            motionWakeYEvent,
  input  wire logic                            motionWakeXEvent,
  output logic                                 irqPinA,
  output logic                                 irqPinB,
  output logic                                 inbandReq
);
  import meir_pkg::*;

  // ==========================================================================
  // Routing register file
  logic [MEIR_DATA_W-1:0]    route [MEIR_REG_COUNT];
  logic [MEIR_REG_COUNT-1:0] wrHit;

  // One instance per register; the write strobe is decoded per offset
  genvar r;
  generate
    for (r = 0; r < MEIR_REG_COUNT; r++)
    begin : g_reg
      assign wrHit[r] = regWrEn && (regAddr == MEIR_OFFSETS[r]);
      meir_route_reg
      #(
        .WRITE_MASK  (MEIR_WRITE_MASKS[r]),
        .RESET_VALUE (MEIR_ROUTE_RESET)
      )
      u_reg
      (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wrEn    (wrHit[r]),
        .wrData  (regWrData),
        .value   (route[r])
      );
    end
  endgenerate

  // Read port: a read in the same cycle as a write returns the old value
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regRdData <= MEIR_READ_IDLE;
    else if (regRdEn)
    begin
      if (regAddr == MEIR_OFS_PIN_A)
        regRdData <= route[MEIR_IDX_PIN_A];
      else if (regAddr == MEIR_OFS_PIN_B)
        regRdData <= route[MEIR_IDX_PIN_B];
      else if (regAddr == MEIR_OFS_SYS_IB)
        regRdData <= route[MEIR_IDX_SYS_IB];
      else if (regAddr == MEIR_OFS_ERR_IB)
        regRdData <= route[MEIR_IDX_ERR_IB];
      else if (regAddr == MEIR_OFS_GEST_IB)
        regRdData <= route[MEIR_IDX_GEST_IB];
      else
        regRdData <= MEIR_READ_IDLE; // Other offsets belong to other blocks
    end
  end

  // Read data is valid the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regRdValid <= 1'b0;
    else
      regRdValid <= regRdEn;
  end

  // ==========================================================================
  // Event gathering, laid out in the same bit order as the routing fields
  logic [MEIR_MOTION_W-1:0] motionVec;
  logic [MEIR_SYSTEM_W-1:0] systemVec;
  logic [MEIR_DATA_W-1:0]   errorVec;

  assign motionVec = {stepEvent, stepOverflowEvent, tiltEvent,
                      wakeEvent, sleepEvent, tapEvent};
  assign systemVec = {frameSyncEvent, pllLockEvent, sampleReadyEvent,
                      fifoLevelEvent, fifoFullEvent, gainReadyEvent};
  assign errorVec  = {busErrorEvent, 2'b00, significantMotionEvent,
                      motionWakeZEvent, motionWakeYEvent, motionWakeXEvent, 1'b0};

  // ==========================================================================
  // Gating per destination
  logic [MEIR_MOTION_W-1:0] gatePinA;
  logic [MEIR_MOTION_W-1:0] gatePinB;
  logic [MEIR_SYSTEM_W-1:0] gateSysIb;
  logic [MEIR_DATA_W-1:0]   gateErrIb;
  logic [MEIR_MOTION_W-1:0] gateGestIb;

  // Pin A motion gates
  assign gatePinA[MEIR_BIT_STEP]  = stepEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_STEP];
  assign gatePinA[MEIR_BIT_OVF]   = stepOverflowEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_OVF];
  assign gatePinA[MEIR_BIT_TILT]  = tiltEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_TILT];
  assign gatePinA[MEIR_BIT_WAKE]  = wakeEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_WAKE];
  assign gatePinA[MEIR_BIT_SLEEP] = sleepEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_SLEEP];
  assign gatePinA[MEIR_BIT_TAP]   = tapEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_TAP];

  // Pin B uses the same field layout, so one mask
  assign gatePinB = motionVec & route[MEIR_IDX_PIN_B][MEIR_MOTION_W-1:0];

  // System in-band gates
  assign gateSysIb[MEIR_BIT_FRAME_SYNC]     =
    frameSyncEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_FRAME_SYNC];
  assign gateSysIb[MEIR_BIT_PLL]       =
    pllLockEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_PLL];
  assign gateSysIb[MEIR_BIT_DRDY]      =
    sampleReadyEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_DRDY];
  assign gateSysIb[MEIR_BIT_FIFO_LVL]  =
    fifoLevelEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_FIFO_LVL];
  assign gateSysIb[MEIR_BIT_FIFO_FULL] =
    fifoFullEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_FIFO_FULL];
  assign gateSysIb[MEIR_BIT_GAIN]      =
    gainReadyEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_GAIN];

  // Error in-band gates; reserved register bits are zero so their lanes stay quiet
  assign gateErrIb = errorVec & route[MEIR_IDX_ERR_IB];

  // Gesture in-band gates
  assign gateGestIb = motionVec & route[MEIR_IDX_GEST_IB][MEIR_MOTION_W-1:0];

  // ==========================================================================
  // Output stage: registered so the pins never glitch while enables change
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irqPinA   <= 1'b0;
      irqPinB   <= 1'b0;
      inbandReq <= 1'b0;
    end
    else
    begin
      irqPinA   <= |gatePinA;
      irqPinB   <= |gatePinB;
      inbandReq <= (|gateSysIb) || (|gateErrIb) || (|gateGestIb);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_step_pin_a;
    stepEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_STEP] |=> irqPinA;
  endproperty
  a_step_pin_a: assert property (p_step_pin_a)
    else $error("step event not seen on pin A");

  property p_ovf_pin_a;
    stepOverflowEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_OVF] |=> irqPinA;
  endproperty
  a_ovf_pin_a: assert property (p_ovf_pin_a)
    else $error("step overflow not seen on pin A");

  property p_tilt_pin_a;
    tiltEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_TILT] |=> irqPinA;
  endproperty
  a_tilt_pin_a: assert property (p_tilt_pin_a)
    else $error("tilt event not seen on pin A");

  property p_wake_sleep_pin_a;
    (wakeEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_WAKE]) ||
    (sleepEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_SLEEP]) |=> irqPinA;
  endproperty
  a_wake_sleep_pin_a: assert property (p_wake_sleep_pin_a)
    else $error("wake or sleep event not seen on pin A");

  property p_tap_pin_a;
    tapEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_TAP] |=> irqPinA;
  endproperty
  a_tap_pin_a: assert property (p_tap_pin_a)
    else $error("tap event not seen on pin A");

  property p_step_pin_b;
    (stepEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_STEP]) ||
    (stepOverflowEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_OVF]) |=> irqPinB;
  endproperty
  a_step_pin_b: assert property (p_step_pin_b)
    else $error("step or overflow not seen on pin B");

  property p_tilt_wake_pin_b;
    (tiltEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_TILT]) ||
    (wakeEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_WAKE]) ||
    (sleepEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_SLEEP]) |=> irqPinB;
  endproperty
  a_tilt_wake_pin_b: assert property (p_tilt_wake_pin_b)
    else $error("tilt, wake or sleep not seen on pin B");

  property p_tap_pin_b;
    tapEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_TAP] |=> irqPinB;
  endproperty
  a_tap_pin_b: assert property (p_tap_pin_b)
    else $error("tap event not seen on pin B");

  property p_sys_inband;
    (frameSyncEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_FRAME_SYNC]) ||
    (pllLockEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_PLL]) |=> inbandReq;
  endproperty
  a_sys_inband: assert property (p_sys_inband)
    else $error("frame sync or PLL lock not seen in-band");

  property p_data_inband;
    (sampleReadyEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_DRDY]) ||
    (fifoLevelEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_FIFO_LVL]) ||
    (fifoFullEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_FIFO_FULL]) ||
    (gainReadyEvent && route[MEIR_IDX_SYS_IB][MEIR_BIT_GAIN]) |=> inbandReq;
  endproperty
  a_data_inband: assert property (p_data_inband)
    else $error("data or gain event not seen in-band");

  property p_err_inband;
    (busErrorEvent && route[MEIR_IDX_ERR_IB][MEIR_BIT_BUS_ERR]) ||
    (significantMotionEvent && route[MEIR_IDX_ERR_IB][MEIR_BIT_SIG_MOT]) ||
    (motionWakeZEvent && route[MEIR_IDX_ERR_IB][MEIR_BIT_WAKE_Z]) ||
    (motionWakeYEvent && route[MEIR_IDX_ERR_IB][MEIR_BIT_WAKE_Y]) ||
    (motionWakeXEvent && route[MEIR_IDX_ERR_IB][MEIR_BIT_WAKE_X]) |=> inbandReq;
  endproperty
  a_err_inband: assert property (p_err_inband)
    else $error("error or motion wake event not seen in-band");

  property p_gest_inband;
    |(motionVec & route[MEIR_IDX_GEST_IB][MEIR_MOTION_W-1:0]) |=> inbandReq;
  endproperty
  a_gest_inband: assert property (p_gest_inband)
    else $error("gesture event not seen in-band");

  property p_reset_clear;
    $past(rst) |-> route[MEIR_IDX_PIN_A] == MEIR_ROUTE_RESET &&
      route[MEIR_IDX_PIN_B] == MEIR_ROUTE_RESET && route[MEIR_IDX_SYS_IB] == MEIR_ROUTE_RESET &&
      route[MEIR_IDX_ERR_IB] == MEIR_ROUTE_RESET && route[MEIR_IDX_GEST_IB] == MEIR_ROUTE_RESET &&
      !irqPinA && !irqPinB && !inbandReq;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("routing not cleared after reset");

  property p_write_err;
    regWrEn && regAddr == MEIR_OFS_ERR_IB |=>
      route[MEIR_IDX_ERR_IB] == ($past(regWrData) & MEIR_MASK_ERROR);
  endproperty
  a_write_err: assert property (p_write_err)
    else $error("error routing register write lost or reserved bit kept");

  property p_read_back;
    regRdEn && regAddr == MEIR_OFS_PIN_B |=>
      regRdValid && regRdData == $past(route[MEIR_IDX_PIN_B]);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("pin B routing read-back mismatch");

  property p_rd_valid_pulse;
    !regRdEn |=> !regRdValid;
  endproperty
  a_rd_valid_pulse: assert property (p_rd_valid_pulse)
    else $error("read valid without a read strobe");

  property p_read_unmapped;
    regRdEn && (regAddr < MEIR_OFS_PIN_A || regAddr > MEIR_OFS_GEST_IB) |=>
      regRdValid && regRdData == MEIR_READ_IDLE;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped offset did not read as zero");

  property p_read_reserved;
    regRdEn && regAddr == MEIR_OFS_ERR_IB |=>
      (regRdData & ~MEIR_MASK_ERROR) == MEIR_READ_IDLE;
  endproperty
  a_read_reserved: assert property (p_read_reserved)
    else $error("reserved error routing bit read back set");

  property p_pin_a_quiet;
    !(|gatePinA) ##1 !(|gatePinA) |-> !irqPinA;
  endproperty
  a_pin_a_quiet: assert property (p_pin_a_quiet)
    else $error("pin A active with no enabled event");

  property p_pin_b_quiet;
    !(|gatePinB) |=> !irqPinB;
  endproperty
  a_pin_b_quiet: assert property (p_pin_b_quiet)
    else $error("pin B active with no enabled event");

  property p_inband_quiet;
    !(|gateSysIb) && !(|gateErrIb) && !(|gateGestIb) |=> !inbandReq;
  endproperty
  a_inband_quiet: assert property (p_inband_quiet)
    else $error("in-band request with no enabled event");

  property p_reserved_zero;
    (route[MEIR_IDX_PIN_A] & ~MEIR_MASK_MOTION) == MEIR_READ_IDLE &&
    (route[MEIR_IDX_PIN_B] & ~MEIR_MASK_MOTION) == MEIR_READ_IDLE &&
    (route[MEIR_IDX_SYS_IB] & ~MEIR_MASK_SYSTEM) == MEIR_READ_IDLE &&
    (route[MEIR_IDX_ERR_IB] & ~MEIR_MASK_ERROR) == MEIR_READ_IDLE &&
    (route[MEIR_IDX_GEST_IB] & ~MEIR_MASK_MOTION) == MEIR_READ_IDLE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved routing bit set");

  // Main scenarios
  c_pin_a_fire: cover property (stepEvent && route[MEIR_IDX_PIN_A][MEIR_BIT_STEP] ##1 irqPinA);
  c_pin_b_tap: cover property (tapEvent && route[MEIR_IDX_PIN_B][MEIR_BIT_TAP] ##1 irqPinB);
  c_err_inband: cover property (busErrorEvent && route[MEIR_IDX_ERR_IB][MEIR_BIT_BUS_ERR]
    ##1 inbandReq);
  c_wr_rd: cover property (wrHit[MEIR_IDX_GEST_IB] ##1 regRdEn && regAddr == MEIR_OFS_GEST_IB);

endmodule : meir_router

// file: testbench/meir_host_model.sv
// Host side model that watches the pin and in-band interrupt requests
`timescale 1ns/1ps
module meir_host_model
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic irqPinA,
  input  wire logic irqPinB,
  input  wire logic inbandReq,
  output int        seenA,
  output int        seenB,
  output int        seenIb
);
  logic [2:0] prevReq;

  // ==========================================================================
  // Edge counters: a host acts on each new assertion, not on a held level
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prevReq <= 3'h0;
      seenA   <= 0;
      seenB   <= 0;
      seenIb  <= 0;
    end
    else
    begin
      prevReq <= {irqPinA, irqPinB, inbandReq};
      if (irqPinA && !prevReq[2]) seenA <= seenA + 1;
      if (irqPinB && !prevReq[1]) seenB <= seenB + 1;
      if (inbandReq && !prevReq[0]) seenIb <= seenIb + 1;
    end
  end
endmodule : meir_host_model

// file: testbench/tb_meir_router.sv
// Self-checking bench for the motion event interrupt router
`timescale 1ns/1ps
module tb_meir_router;
  import meir_pkg::*;
  logic        clk_sys, rst, regWrEn, regRdEn, regRdValid;
  logic [6:0]  regAddr;
  logic [7:0]  regWrData, regRdData, erd;
  logic [16:0] ev;
  logic        irqPinA, irqPinB, inbandReq, erv;
  logic [2:0]  eo;
  logic [7:0]  mreg [5];
  logic [31:0] rng = 32'h11bf;
  int          numErrors = 0;
  int          testsRun = 0;
  int          seenA, seenB, seenIb;

  // ==========================================================================
  // Design and host model
  meir_router u_meir_router (.clk_sys(clk_sys), .rst(rst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .stepEvent(ev[5]), .stepOverflowEvent(ev[4]),
    .tiltEvent(ev[3]), .wakeEvent(ev[2]), .sleepEvent(ev[1]), .tapEvent(ev[0]),
    .frameSyncEvent(ev[11]), .pllLockEvent(ev[10]), .sampleReadyEvent(ev[9]),
    .fifoLevelEvent(ev[8]), .fifoFullEvent(ev[7]), .gainReadyEvent(ev[6]),
    .busErrorEvent(ev[16]), .significantMotionEvent(ev[15]), .motionWakeZEvent(ev[14]),
    .motionWakeYEvent(ev[13]), .motionWakeXEvent(ev[12]), .irqPinA(irqPinA),
    .irqPinB(irqPinB), .inbandReq(inbandReq));
  meir_host_model u_meir_host_model (.clk_sys(clk_sys), .rst(rst), .irqPinA(irqPinA),
    .irqPinB(irqPinB), .inbandReq(inbandReq), .seenA(seenA), .seenB(seenB),
    .seenIb(seenIb));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : nxt

  function automatic int ix(input logic [6:0] a);
    for (int k = 0; k < MEIR_REG_COUNT; k++)
      if (a === MEIR_OFFSETS[k]) return k;
    return -1;
  endfunction : ix

  // Expected {pin A, pin B, in-band} from the mirrored enables
  function automatic logic [2:0] route(input logic [16:0] e);
    logic [7:0] errVec;
    errVec = {e[16], 2'b00, e[15:12], 1'b0};
    return {|(mreg[0][5:0] & e[5:0]), |(mreg[1][5:0] & e[5:0]),
            |(mreg[2][5:0] & e[11:6]) | |(mreg[3] & errVec) | |(mreg[4][5:0] & e[5:0])};
  endfunction : route

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    testsRun++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic reportAndStop();
    $display("errors %0d checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : reportAndStop

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // One bus cycle; strobes stay as given until the next call
  task automatic bus(input logic we, input logic re, input logic [6:0] a,
                     input logic [7:0] d);
    regWrEn   = we;
    regRdEn   = re;
    regAddr   = a;
    regWrData = d;
    tick();
  endtask : bus

  // ==========================================================================
  // Reference mirror: reserved bits masked, one-cycle output and read latency
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mreg <= '{default: 8'h00};
      eo   <= 3'h0;
      erv  <= 1'b0;
      erd  <= 8'h00;
    end
    else
    begin
      eo  <= route(ev);
      erv <= regRdEn;
      if (regRdEn) erd <= (ix(regAddr) < 0) ? MEIR_READ_IDLE : mreg[ix(regAddr)];
      if (regWrEn && ix(regAddr) >= 0)
        mreg[ix(regAddr)] <= regWrData & MEIR_WRITE_MASKS[ix(regAddr)];
    end
  end

  // Cycle-by-cycle comparison of both pins, the in-band request and read valid; read data only when valid
  always @(posedge clk_sys)
  begin
    if (!rst)
    begin
      chk(irqPinA, eo[2], "pin A");
      chk(irqPinB, eo[1], "pin B");
      chk(inbandReq, eo[0], "in-band");
      chk(regRdValid, erv, "read valid");
      if (erv) chk(regRdData, erd, "read data");
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Watchdog so a hang still ends in the report
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    numErrors++;
    $display("[FAIL] %0t run limit reached", $time);
    reportAndStop();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ev  = 17'h0;
    bus(1'b0, 1'b0, 7'h00, 8'h00);
    repeat (2) tick();
    rst = 1'b0;
    // Reset values, then all ones to find reserved bits, neighbours unmapped
    for (int a = 'h4c; a <= 'h52; a++) bus(1'b0, 1'b1, a[6:0], 8'h00);
    for (int a = 'h4c; a <= 'h52; a++) bus(1'b1, 1'b1, a[6:0], 8'hff);
    for (int a = 'h4c; a <= 'h52; a++) bus(1'b0, 1'b1, a[6:0], 8'h00);
    // Walking enable with every event pending: one bit at a time; registers not yet walked keep the all-ones write
    ev = '1;
    for (int r = 0; r < MEIR_REG_COUNT; r++)
      for (int b = 0; b < 8; b++)
      begin
        bus(1'b1, 1'b0, MEIR_OFFSETS[r], 8'h01 << b);
        bus(1'b0, 1'b1, MEIR_OFFSETS[r], 8'h00);
        bus(1'b1, 1'b0, MEIR_OFFSETS[r], 8'h00);
      end
    // Random traffic: strobes, addresses and sparse events together
    for (int n = 0; n < 4000; n++)
    begin
      if (n == 2000) rst = 1'b1;
      if (n == 2003) rst = 1'b0;
      ev = 17'(nxt() >> 15);
      ev = ev & 17'(nxt());
      bus(rng[0], rng[1], 7'h4c + 7'(rng[4:2]), rng[15:8]);
    end
    bus(1'b0, 1'b0, 7'h00, 8'h00);
    chk(8'(seenA > 0 && seenB > 0 && seenIb > 0), 8'h01, "host saw requests");
    reportAndStop();
  end
endmodule : tb_meir_router
